//--- src/bcc_exec.sv
// Execution unit for bit clear, compare, BCD string compare and block compare
`timescale 1ns/1ps
`default_nettype none
module bcc_exec
    import bcc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Instruction bytes
    input wire logic start,
    input wire logic [7:0] ib0,
    input wire logic [7:0] ib1,
    input wire logic [7:0] ib2,
    input wire logic [7:0] ib3,
    input wire logic [7:0] ib4,
    input wire logic [7:0] ib5,
    input wire logic [2:0] disp_len,
    input wire logic [1:0] seg_override,
    input wire logic seg_override_valid,
    // Operands
    input wire logic [15:0] dst_operand,
    input wire logic [15:0] src_operand,
    input wire logic [15:0] acc_word,
    input wire logic [7:0] count_low_reg,
    input wire logic [15:0] source_index_reg,
    input wire logic [15:0] dest_index_reg,
    // Memory bytes for BCD compare
    input wire logic [7:0] bcd_dst_byte,
    input wire logic [7:0] bcd_src_byte,
    // Results
    output logic done,
    output logic [2:0] instr_len,
    output logic wb_en,
    output logic [15:0] wb_data,
    output logic [5:0] flags,
    output logic [5:0] flags_valid,
    output logic dir_flag,
    output logic [15:0] next_source_index,
    output logic [15:0] next_dest_index,
    output logic [1:0] src_seg,
    output logic [1:0] dst_seg,
    output logic [7:0] bcd_byte_idx,
    output logic busy
);
    // ==========================================
    // Decode
    logic is_prefix;
    logic is_clrbit;
    logic is_bcd;
    logic is_acc;
    logic is_blk;
    logic wbit;
    logic [3:0] bitnum;
    logic [7:0] imm_byte;
    logic [15:0] cleared;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] diff;
    logic [5:0] sub_flags;
    logic [15:0] step;
    logic [7:0] bcd_total;
    logic [15:0] bcd_diff;
    logic [5:0] bcd_flags;
    logic bcd_borrow;
    logic bcd_nz;
    state_t state;
    always_comb begin
        is_prefix = (ib0 == OP_PREFIX);
        // Immediate select bit is masked out so both count and immediate forms decode
        is_clrbit = is_prefix && ((ib1[7:1] & OP_CLRBIT_MASK) == OP_CLRBIT_HI);
        is_bcd = is_prefix && (ib1 == OP_BCD_CMP);
        is_acc = (ib0[7:1] == OP_ACC_CMP);
        is_blk = (ib0[7:1] == OP_BLK_CMP);
        wbit = is_prefix ? ib1[W_BIT] : ib0[W_BIT];
        // Immediate byte is byte four for registers, else after displacement
        unique case (disp_len)
            3'h1: imm_byte = ib4;
            3'h2: imm_byte = ib5;
            default: imm_byte = ib3;
        endcase
        if (ib1[IMM_BIT]) begin
            bitnum = wbit ? imm_byte[3:0] : {1'b0, imm_byte[2:0]};
        end else begin
            bitnum = wbit ? count_low_reg[3:0] : {1'b0, count_low_reg[2:0]};
        end
        cleared = dst_operand & ~(16'h0001 << bitnum);
        if (is_acc) begin
            cmp_a = wbit ? acc_word : {8'h00, acc_word[7:0]};
            cmp_b = wbit ? {ib2, ib1} : {8'h00, ib1};
        end else begin
            cmp_a = wbit ? dst_operand : {8'h00, dst_operand[7:0]};
            cmp_b = wbit ? src_operand : {8'h00, src_operand[7:0]};
        end
        step = wbit ? 16'h0002 : 16'h0001;
        bcd_total = count_low_reg + {7'h00, count_low_reg[0]};
    end
    bcc_sub u_sub (
        .a(cmp_a),
        .b(cmp_b),
        .borrow_in(1'b0),
        .word(wbit),
        .diff(diff),
        .flags(sub_flags)
    );
    bcc_sub u_bcd (
        .a({8'h00, bcd_dst_byte}),
        .b({8'h00, bcd_src_byte}),
        .borrow_in(bcd_borrow),
        .word(1'b0),
        .diff(bcd_diff),
        .flags(bcd_flags)
    );
    // ==========================================
    // Sequencer for the BCD string compare
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state <= ST_IDLE;
            bcd_byte_idx <= 8'h00;
            bcd_borrow <= 1'b0;
            bcd_nz <= 1'b0;
            busy <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (start && is_bcd) begin
                        state <= ST_BCD;
                        busy <= 1'b1;
                        bcd_byte_idx <= 8'h00;
                        bcd_borrow <= 1'b0;
                        bcd_nz <= 1'b0;
                    end
                end
                ST_BCD: begin
                    // Digit pairs per byte; destination minus source with decimal borrow
                    bcd_borrow <= (bcd_dst_byte < bcd_src_byte) ||
                                  ((bcd_dst_byte == bcd_src_byte) && bcd_borrow);
                    bcd_nz <= bcd_nz | (bcd_diff[7:0] != 8'h00);
                    bcd_byte_idx <= bcd_byte_idx + 8'h01;
                    if ({bcd_byte_idx, 1'b0} + 9'h002 >= {1'b0, bcd_total}) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                    busy <= 1'b0;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
    // ==========================================
    // Results
    always_ff @(posedge core_clk) begin
        if (srst) begin
            done <= 1'b0;
            instr_len <= 3'h0;
            wb_en <= 1'b0;
            wb_data <= 16'h0000;
            flags <= FLAGS_RST;
            flags_valid <= 6'h00;
            next_source_index <= 16'h0000;
            next_dest_index <= 16'h0000;
            src_seg <= SEG_DS0;
            dst_seg <= SEG_DS1;
        end else begin
            done <= 1'b0;
            wb_en <= 1'b0;
            flags_valid <= 6'h00;
            if (state == ST_DONE) begin
                done <= 1'b1;
                instr_len <= LEN_BCD;
                flags <= {1'b0, bcd_borrow, 3'b000, ~bcd_nz};
                flags_valid <= 6'b010001;
            end else if (start && state == ST_IDLE && !is_bcd) begin
                done <= 1'b1;
                if (is_clrbit) begin
                    wb_en <= 1'b1;
                    wb_data <= cleared;
                    instr_len <= (ib1[IMM_BIT] ? LEN_IMM : LEN_CNT) + disp_len;
                end else if (ib0 == OP_CLR_CARRY) begin
                    flags[4] <= 1'b0;
                    flags_valid <= 6'b010000;
                    instr_len <= LEN_FLAG;
                end else if (ib0 == OP_CLR_DIR) begin
                    instr_len <= LEN_FLAG;
                end else if (is_acc) begin
                    flags <= sub_flags;
                    flags_valid <= 6'h3f;
                    instr_len <= wbit ? 3'h3 : 3'h2;
                end else begin
                    flags <= sub_flags;
                    flags_valid <= 6'h3f;
                    instr_len <= is_blk ? LEN_FLAG : 3'h2 + disp_len;
                    if (is_blk) begin
                        next_source_index <= dir_flag ? source_index_reg - step
                                                      : source_index_reg + step;
                        next_dest_index <= dir_flag ? dest_index_reg - step : dest_index_reg + step;
                    end
                end
            end
            if (start && state == ST_IDLE) begin
                src_seg <= seg_override_valid ? seg_override : SEG_DS0;
                dst_seg <= SEG_DS1;
            end
        end
    end
    // Direction flag, cleared by its single-byte form
    always_ff @(posedge core_clk) begin
        if (srst) begin
            dir_flag <= DIR_RST;
        end else if (start && state == ST_IDLE && ib0 == OP_CLR_DIR) begin
            dir_flag <= 1'b0;
        end
    end
    // ==========================================
    // Checks
    chk_dir_upward: assert property (@(posedge core_clk) disable iff (srst)
        (start && state == ST_IDLE && ib0 == OP_CLR_DIR) |=> !dir_flag)
        else $error("direction not cleared");
    chk_bit_cleared: assert property (@(posedge core_clk) disable iff (srst)
        (start && state == ST_IDLE && is_clrbit) |=> wb_en && wb_data[$past(bitnum)] == 1'b0)
        else $error("bit not cleared");
    chk_clrbit_flags: assert property (@(posedge core_clk) disable iff (srst)
        (start && state == ST_IDLE && is_clrbit) |=> flags_valid == 6'h00)
        else $error("bit clear touched flags");
    chk_carry_only: assert property (@(posedge core_clk) disable iff (srst)
        (start && state == ST_IDLE && ib0 == OP_CLR_CARRY) |=> flags_valid == 6'b010000 && !flags[4])
        else $error("carry clear wrong");
    chk_dst_segment: assert property (@(posedge core_clk) disable iff (srst)
        dst_seg == SEG_DS1)
        else $error("destination segment moved");
    chk_blk_step: assert property (@(posedge core_clk) disable iff (srst)
        (start && state == ST_IDLE && is_blk && !dir_flag) |=>
        next_source_index == $past(source_index_reg) + $past(step))
        else $error("block step wrong");
    chk_bcd_length: assert property (@(posedge core_clk) disable iff (srst)
        (state == ST_DONE) |-> {bcd_byte_idx, 1'b0} >= {1'b0, bcd_total})
        else $error("bcd length wrong");
    chk_bcd_flags: assert property (@(posedge core_clk) disable iff (srst)
        (state == ST_DONE) |=> done && flags_valid == 6'b010001)
        else $error("bcd flags wrong");
endmodule
`default_nettype wire

//--- src/bcc_pkg.sv
// Package: constants for the bit-clear and compare execution block
// Notes on behaviour
// - Bit clear forces the chosen destination bit to zero and writes it back.
// - Byte destination with count-low bit number uses its low three bits.
// - Word destination with count-low bit number uses its low four bits.
// - Register immediate byte form takes bit number from low three bits of byte four.
// - Register immediate word form takes bit number from low four bits of byte four.
// - Memory immediate forms take bit number from the final instruction byte.
// - Carry clear form zeroes carry and leaves other flags alone.
// - Direction clear makes string instructions step index registers upward.
// - Bit clear is a two-byte opcode; width bit 0, immediate bit 3.
// - Instruction lengths: count forms 3, immediate 4, plus displacement; flag forms 1.
// - Compare subtracts source from destination, keeps only six arithmetic flags.
// - Accumulator compare uses low byte or whole word by the width bit.
// - Accumulator compare opcode is 0011110w followed by one or two immediates.
// - BCD string compare subtracts source from destination string, flags only.
// - Destination string uses second data segment; source segment may be overridden.
// - Odd BCD digit counts are run as count plus one.
// - Byte block compare subtracts source from destination, steps indexes by one.
// - Word block compare compares words, steps indexes by two.
// - Block compare sets all six flags; destination segment fixed.
package bcc_pkg;
    // ==========================================
    // Opcodes
    localparam logic [7:0] OP_PREFIX = 8'h0f;
    localparam logic [7:0] OP_CLR_CARRY = 8'hf8;
    localparam logic [7:0] OP_CLR_DIR = 8'hfc;
    localparam logic [6:0] OP_ACC_CMP = 7'h1e;
    localparam logic [6:0] OP_CLRBIT_HI = 7'h09;
    localparam logic [6:0] OP_CLRBIT_MASK = 7'h7b;
    localparam logic [7:0] OP_BCD_CMP = 8'h26;
    localparam logic [6:0] OP_BLK_CMP = 7'h53;
    localparam int W_BIT = 0;
    localparam int IMM_BIT = 3;
    // ==========================================
    // Lengths
    localparam logic [2:0] LEN_FLAG = 3'h1;
    localparam logic [2:0] LEN_CNT = 3'h3;
    localparam logic [2:0] LEN_IMM = 3'h4;
    localparam logic [2:0] LEN_BCD = 3'h2;
    // ==========================================
    // Reset values
    localparam logic [5:0] FLAGS_RST = 6'h00;
    localparam logic DIR_RST = 1'b0;
    // Segment selectors
    localparam logic [1:0] SEG_DS0 = 2'h0;
    localparam logic [1:0] SEG_DS1 = 2'h1;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BCD = 2'b01,
        ST_DONE = 2'b10
    } state_t;
endpackage

//--- src/bcc_sub.sv
// Subtractor producing the six arithmetic flags
`timescale 1ns/1ps
`default_nettype none
module bcc_sub
    import bcc_pkg::*;
(
    // Operands
    input wire logic [15:0] a,
    input wire logic [15:0] b,
    input wire logic borrow_in,
    input wire logic word,
    // Result
    output logic [15:0] diff,
    output logic [5:0] flags
);
    logic [16:0] full;
    logic [4:0] low;
    logic cy;
    logic ov;
    always_comb begin
        full = {1'b0, a} - {1'b0, b} - {16'h0000, borrow_in};
        low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, borrow_in};
        diff = full[15:0];
        if (word) begin
            cy = full[16];
            ov = (a[15] ^ b[15]) & (a[15] ^ full[15]);
        end else begin
            cy = (a[8] ^ b[8] ^ full[8]);
            ov = (a[7] ^ b[7]) & (a[7] ^ full[7]);
        end
        // Order: aux, carry, overflow, parity, sign, zero
        flags = {low[4], cy, ov, ~^full[7:0], word ? full[15] : full[7],
                 word ? (full[15:0] == 16'h0000) : (full[7:0] == 8'h00)};
    end
endmodule
`default_nettype wire

//--- bench/bcc_mem_model.sv
// Behavioural model of the data memory holding the two packed decimal strings
`timescale 1ns/1ps
`default_nettype none
module bcc_mem_model (
    // Byte index from the block
    input wire logic [7:0] bcd_byte_idx,
    // Bytes of the two strings
    output logic [7:0] bcd_dst_byte,
    output logic [7:0] bcd_src_byte
);
    logic [7:0] dst_mem [0:1];
    logic [7:0] src_mem [0:1];
    // ==========================================
    // Loading
    task automatic load(input logic [7:0] d0, input logic [7:0] d1, input logic [7:0] s0, input logic [7:0] s1);
        dst_mem[0] = d0;
        dst_mem[1] = d1;
        src_mem[0] = s0;
        src_mem[1] = s1;
    endtask
    // ==========================================
    // Byte supply; past the strings the bytes are scrambled
    always_comb begin
        if (bcd_byte_idx < 8'h02) begin
            bcd_dst_byte = dst_mem[bcd_byte_idx[0]];
            bcd_src_byte = src_mem[bcd_byte_idx[0]];
        end else begin
            bcd_dst_byte = ~bcd_byte_idx;
            bcd_src_byte = bcd_byte_idx ^ 8'h5a;
        end
    end
endmodule
`default_nettype wire

//--- bench/bit_clear_and_compare_exec_tb.sv
// Self-checking testbench of the bit clear and compare execution block
`timescale 1ns/1ps
`default_nettype none
module bit_clear_and_compare_exec_tb;
    logic core_clk = 1'b0, srst = 1'b1, start = 1'b0, seg_override_valid = 1'b0;
    logic [7:0] ib0 = 8'h00, ib1 = 8'h00, ib2 = 8'h00, ib3 = 8'h00, ib4 = 8'h00, ib5 = 8'h00;
    logic [2:0] disp_len = 3'h0;
    logic [1:0] seg_override = 2'h0;
    logic [15:0] dst_operand = 16'h0000, src_operand = 16'h0000, acc_word = 16'h0000;
    logic [15:0] source_index_reg = 16'h0000, dest_index_reg = 16'h0000;
    logic [7:0] count_low_reg = 8'h00;
    wire logic [7:0] bcd_dst_byte, bcd_src_byte, bcd_byte_idx;
    logic done, wb_en, dir_flag, busy;
    logic [2:0] instr_len;
    logic [15:0] wb_data, next_source_index, next_dest_index;
    logic [5:0] flags, flags_valid;
    logic [1:0] src_seg, dst_seg;
    int fails = 0, checks = 0;
    // ==========================================
    // Design and memory model
    bcc_exec dut (.core_clk(core_clk), .srst(srst), .start(start), .ib0(ib0), .ib1(ib1), .ib2(ib2),
        .ib3(ib3), .ib4(ib4), .ib5(ib5), .disp_len(disp_len), .seg_override(seg_override),
        .seg_override_valid(seg_override_valid), .dst_operand(dst_operand), .src_operand(src_operand),
        .acc_word(acc_word), .count_low_reg(count_low_reg), .source_index_reg(source_index_reg),
        .dest_index_reg(dest_index_reg), .bcd_dst_byte(bcd_dst_byte), .bcd_src_byte(bcd_src_byte),
        .done(done), .instr_len(instr_len), .wb_en(wb_en), .wb_data(wb_data), .flags(flags),
        .flags_valid(flags_valid), .dir_flag(dir_flag), .next_source_index(next_source_index),
        .next_dest_index(next_dest_index), .src_seg(src_seg), .dst_seg(dst_seg),
        .bcd_byte_idx(bcd_byte_idx), .busy(busy));
    bcc_mem_model mem (.bcd_byte_idx(bcd_byte_idx), .bcd_dst_byte(bcd_dst_byte), .bcd_src_byte(bcd_src_byte));
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    // ==========================================
    // Tasks
    task automatic tally_and_finish;
        if (fails == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic run(input logic [7:0] b0, b1, b2, b3, b4, input logic [2:0] dl);
        int n;
        n = 0;
        @(posedge core_clk);
        #1;
        ib0 = b0;
        ib1 = b1;
        ib2 = b2;
        ib3 = b3;
        ib4 = b4;
        disp_len = dl;
        start = 1'b1;
        @(posedge core_clk);
        #1 start = 1'b0;
        while (done !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            #1 n++;
        end
        if (n >= 40) begin
            fails++;
            tally_and_finish;
        end
    endtask
    task automatic csz(input logic [2:0] exp);
        chk("carry_sign_zero", 16'(exp), 16'({flags[4], flags[1], flags[0]}));
    endtask
    task automatic clr(input logic [7:0] b1, b2, b3, b4, input logic [2:0] dl, input logic [7:0] cl,
        input logic [15:0] dst, input logic [15:0] exp_wb, input logic [2:0] exp_len);
        count_low_reg = cl;
        dst_operand = dst;
        run(8'h0f, b1, b2, b3, b4, dl);
        chk("wb_en", 16'h0001, 16'(wb_en));
        chk("wb_data", exp_wb, wb_data);
        chk("instr_len", 16'(exp_len), 16'(instr_len));
        chk("flags_valid", 16'h0000, 16'(flags_valid));
        csz(3'b110);
    endtask
    // ==========================================
    // Scenarios
    initial begin
        repeat (12) @(posedge core_clk);
        #1 srst = 1'b0;
        acc_word = 16'h0005;
        run(8'h3c, 8'h07, 8'h00, 8'h00, 8'h00, 3'h0);
        chk("flags_valid", 16'h003f, 16'(flags_valid));
        csz(3'b110);
        clr(8'h12, 8'hc0, 8'h00, 8'h00, 3'h0, 8'h0b, 16'h00ff, 16'h00f7, 3'h3);
        clr(8'h13, 8'hc1, 8'h00, 8'h00, 3'h0, 8'h1b, 16'hffff, 16'hf7ff, 3'h3);
        clr(8'h1a, 8'hc2, 8'hfd, 8'h00, 3'h0, 8'h00, 16'h00ff, 16'h00df, 3'h4);
        clr(8'h1b, 8'hc3, 8'hfe, 8'h00, 3'h0, 8'h00, 16'hffff, 16'hbfff, 3'h4);
        clr(8'h1b, 8'h46, 8'h10, 8'hf9, 3'h1, 8'h00, 16'hffff, 16'hfdff, 3'h5);
        ib5 = 8'hfc;
        clr(8'h1a, 8'h86, 8'h10, 8'h20, 3'h2, 8'h00, 16'h00ff, 16'h00ef, 3'h6);
        clr(8'h12, 8'h86, 8'h10, 8'h20, 3'h2, 8'hfe, 16'h00ff, 16'h00bf, 3'h5);
        run(8'hf8, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0);
        chk("flags_valid", 16'h0010, 16'(flags_valid));
        csz(3'b010);
        chk("instr_len", 16'h0001, 16'(instr_len));
        acc_word = 16'h1234;
        run(8'h3d, 8'h34, 8'h12, 8'h00, 8'h00, 3'h0);
        csz(3'b001);
        acc_word = 16'h1200;
        run(8'h3c, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0);
        csz(3'b001);
        dst_operand = 16'h0030;
        src_operand = 16'h0040;
        run(8'h3a, 8'hc1, 8'h00, 8'h00, 8'h00, 3'h0);
        csz(3'b110);
        run(8'hfc, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0);
        chk("dir_flag", 16'h0000, 16'(dir_flag));
        chk("instr_len", 16'h0001, 16'(instr_len));
        source_index_reg = 16'hffff;
        dest_index_reg = 16'h0200;
        dst_operand = 16'h0055;
        src_operand = 16'h0055;
        run(8'ha6, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0);
        chk("next_source_index", 16'h0000, next_source_index);
        chk("next_dest_index", 16'h0201, next_dest_index);
        chk("flags_valid", 16'h003f, 16'(flags_valid));
        csz(3'b001);
        chk("src_seg", 16'h0000, 16'(src_seg));
        seg_override = 2'h3;
        seg_override_valid = 1'b1;
        source_index_reg = 16'h0100;
        run(8'ha7, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0);
        chk("next_source_index", 16'h0102, next_source_index);
        chk("next_dest_index", 16'h0202, next_dest_index);
        chk("src_seg", 16'h0003, 16'(src_seg));
        chk("dst_seg", 16'h0001, 16'(dst_seg));
        mem.load(8'h34, 8'h12, 8'h34, 8'h12);
        count_low_reg = 8'h04;
        run(8'h0f, 8'h26, 8'h00, 8'h00, 8'h00, 3'h0);
        chk("flags_valid", 16'h0011, 16'(flags_valid));
        csz(3'b001);
        seg_override = 2'h2;
        mem.load(8'h34, 8'h02, 8'h34, 8'h12);
        count_low_reg = 8'h03;
        run(8'h0f, 8'h26, 8'h00, 8'h00, 8'h00, 3'h0);
        chk("carry_zero", 16'h0002, 16'({flags[4], flags[0]}));
        chk("src_seg", 16'h0002, 16'(src_seg));
        chk("dst_seg", 16'h0001, 16'(dst_seg));
        seg_override_valid = 1'b0;
        mem.load(8'h34, 8'h02, 8'h34, 8'h02);
        run(8'h0f, 8'h26, 8'h00, 8'h00, 8'h00, 3'h0);
        chk("carry_zero", 16'h0001, 16'({flags[4], flags[0]}));
        chk("src_seg", 16'h0000, 16'(src_seg));
        tally_and_finish;
    end
endmodule
`default_nettype wire
